// >>> vpiu_cfg.svh
// Constants of the vectored priority interrupt unit
`ifndef VPIU_CFG_SVH
`define VPIU_CFG_SVH

// ****************************************************************
// Flag indices, highest priority maskable group first, NMI last
// ****************************************************************
`define VPIU_SRC_TMA   4'h0
`define VPIU_SRC_TMB   4'h1
`define VPIU_SRC_EXR   4'h2
`define VPIU_SRC_EXF   4'h3
`define VPIU_SRC_ECA   4'h4
`define VPIU_SRC_ECB   4'h5
`define VPIU_SRC_CIE   4'h6
`define VPIU_SRC_ADC   4'h7
`define VPIU_SRC_RXF   4'h8
`define VPIU_SRC_TXE   4'h9
`define VPIU_SRC_NMI   4'ha
`define VPIU_NUM_MSK   10

// ****************************************************************
// Vectors
// ****************************************************************
`define VPIU_VEC_NMI   16'h0004
`define VPIU_VEC_G2    16'h0008
`define VPIU_VEC_G3    16'h0010
`define VPIU_VEC_G4    16'h0018
`define VPIU_VEC_G5    16'h0020
`define VPIU_VEC_G6    16'h0028
`define VPIU_VEC_TRAP  16'h0060

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define VPIU_MASK_RST  10'h3ff
`define VPIU_ACK_STATES 16
`define VPIU_SKIP_BIT  5
`define VPIU_EXT_MIN_NS 40
`define VPIU_CLK_NS    4
`define VPIU_EXT_CYC   ((`VPIU_EXT_MIN_NS + `VPIU_CLK_NS - 1) / `VPIU_CLK_NS)

`endif

// >>> vpiu_pkg.sv
// Types of the vectored priority interrupt unit
package vpiu_pkg;
    // Acknowledge sequencer states, Gray along the usual path except the VEC to IDLE return
    typedef enum logic [2:0] {
        VPIU_IDLE = 3'h0,
        VPIU_PSW  = 3'h1,
        VPIU_PCH  = 3'h3,
        VPIU_PCL  = 3'h2,
        VPIU_VEC  = 3'h6
    } vpiu_state_e;
    // Kind of service in progress
    typedef enum logic [1:0] {
        VPIU_K_NMI  = 2'h0,
        VPIU_K_MSK  = 2'h1,
        VPIU_K_TRAP = 2'h2
    } vpiu_kind_e;
endpackage

// >>> vpiu_pin_filter.sv
// Pin edge detector with minimum active level persistence
`timescale 1ns/1ps
`include "vpiu_cfg.svh"

module vpiu_pin_filter #(
    parameter logic       ACT_HIGH = 1'b1, // Active level of the pin
    parameter logic [7:0] MIN_CYC  = 8'h01 // Cycles the level must last
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_pin,        // Raw pin level
    output logic      o_event       // One cycle pulse when qualified
);
    logic [7:0] cnt;                // Persistence counter
    logic       armed;              // Waiting for inactive level
    wire        active = (i_pin == ACT_HIGH);
    wire        hit    = active && !armed && (cnt == MIN_CYC);

    // ****************************************************************
    // Counter and edge pulse
    // ****************************************************************
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt     <= 8'h00;
            armed   <= 1'b1;
            o_event <= 1'b0;
        end else begin
            o_event <= hit;
            if (!active) begin
                // Inactive level re-arms detection
                cnt   <= 8'h00;
                armed <= 1'b0;
            end else if (hit) begin
                armed <= 1'b1;
            end else if (!armed) begin
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule

// >>> vpiu_core.sv
// Vectored priority interrupt unit: flags, mask, priority, acknowledge
`timescale 1ns/1ps
`include "vpiu_cfg.svh"

module vpiu_core (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    // Request sources
    input  wire logic       i_nmi_pin_n,           // Nonmaskable pin
    input  wire logic       i_timer_a_match_irq,   // Timer A match
    input  wire logic       i_timer_b_match_irq,   // Timer B match
    input  wire logic       i_ext_rising_pin,      // External rising pin
    input  wire logic       i_ext_falling_pin,     // External falling pin
    input  wire logic       i_event_cmp_a_irq,     // Event compare A
    input  wire logic       i_event_cmp_b_irq,     // Event compare B
    input  wire logic       i_counter_input_pin,   // Counter input pin
    input  wire logic       i_timer_output,        // Timer output level
    input  wire logic       i_converter_done_irq,  // All results stored
    input  wire logic       i_rx_full_irq,         // Receive buffer full
    input  wire logic       i_tx_empty_irq,        // Transmit buffer empty
    // Test flag sources
    input  wire logic       i_counter_overflow_test, // Counter overflow
    input  wire logic       i_serial_error_test,   // Serial error
    input  wire logic       i_supply_rise_test,    // Supply rise
    input  wire logic [3:0] i_analog_pin,          // Analog edge pins
    // Core instruction interface
    input  wire logic       i_instr_end,           // Instruction boundary
    input  wire logic       i_enable_irq_instr,    // Enable instruction
    input  wire logic       i_disable_irq_instr,   // Disable instruction
    input  wire logic       i_software_trap_instr, // Trap at boundary
    input  wire logic       i_skip_pending,        // Skip condition met
    input  wire logic       i_hw_stop,             // Hardware stop entry
    input  wire logic       i_mask_set,            // Set one mask bit
    input  wire logic       i_mask_clr,            // Clear one mask bit
    input  wire logic [3:0] i_mask_sel,            // Mask bit index
    input  wire logic       i_test_req,            // Skip test strobe
    input  wire logic [4:0] i_test_sel,            // Item to test
    input  wire logic [7:0] i_status_word,         // Core status word
    input  wire logic [15:0] i_pc,                 // Return address
    // Outputs to core
    output logic            o_busy,                // Fetch must stall
    output logic            o_push_valid,          // Stack push strobe
    output logic [7:0]      o_push_data,           // Stacked byte
    output logic            o_vector_valid,        // Load vector strobe
    output logic [15:0]     o_vector,              // Target address
    output logic            o_test_result,         // Tested bit value
    output logic            o_global_enable_ff,    // Enable state
    output logic [9:0]      o_mask,                // Mask contents
    output logic [10:0]     o_flags                // Request flags
);
    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [10:0] flags;               // Request flags, NMI at top
    logic [9:0]  mask;                // One masks a source
    logic [6:0]  tflags;              // Non-interrupting test flags
    logic        global_enable_ff;    // Maskable enable
    logic        nmi_q;               // Pin history for edges
    logic        ci_q;
    logic        to_q;
    logic [3:0]  an_q;
    vpiu_pkg::vpiu_state_e state;     // Acknowledge sequencer
    vpiu_pkg::vpiu_state_e next_state;
    vpiu_pkg::vpiu_kind_e  kind;      // Service type held
    logic [3:0]  cyc;                 // Cycles inside one step
    logic [15:0] vec_hold;            // Vector latched at start
    logic [15:0] pc_hold;             // Return address latched
    logic [7:0]  psw_hold;            // Status word latched
    logic [10:0] ack_clr;             // Flags cleared by acknowledge

    // ****************************************************************
    // External pins qualified by persistence
    // ****************************************************************
    logic ext_r_ev;
    logic ext_f_ev;
    vpiu_pin_filter #(.ACT_HIGH(1'b1), .MIN_CYC(8'(`VPIU_EXT_CYC))) u_rise (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_pin     (i_ext_rising_pin),
        .o_event   (ext_r_ev)
    );
    vpiu_pin_filter #(.ACT_HIGH(1'b0), .MIN_CYC(8'(`VPIU_EXT_CYC))) u_fall (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_pin     (i_ext_falling_pin),
        .o_event   (ext_f_ev)
    );

    // ****************************************************************
    // Set events
    // ****************************************************************
    wire nmi_fall = nmi_q && !i_nmi_pin_n;
    wire ci_fall  = (ci_q && !i_counter_input_pin) ||
                    (to_q && !i_timer_output);
    wire [10:0] set_ev = {nmi_fall, i_tx_empty_irq, i_rx_full_irq,
                          i_converter_done_irq, ci_fall,
                          i_event_cmp_b_irq, i_event_cmp_a_irq,
                          ext_f_ev, ext_r_ev,
                          i_timer_b_match_irq, i_timer_a_match_irq};
    wire [3:0] an_fall = an_q & ~i_analog_pin;
    wire [6:0] tset = {an_fall, i_supply_rise_test,
                       i_serial_error_test, i_counter_overflow_test};

    // ****************************************************************
    // Priority: unmasked pending flags per group
    // ****************************************************************
    wire [9:0] elig  = flags[9:0] & ~mask;
    wire [4:0] g_req = {|elig[9:8], |elig[7:6], |elig[5:4],
                        |elig[3:2], |elig[1:0]};
    wire       msk_take = global_enable_ff && (|g_req);
    wire       nmi_take = flags[`VPIU_SRC_NMI];
    wire       start = (state == vpiu_pkg::VPIU_IDLE) && i_instr_end &&
                       (nmi_take || msk_take || i_software_trap_instr);

    // Lowest set group index wins
    function automatic logic [2:0] pick(input logic [4:0] r);
        logic [2:0] g;
        g = 3'h4;
        for (int i = 4; i >= 0; i--) begin
            if (r[i]) g = 3'(i);
        end
        return g;
    endfunction
    wire [2:0] grp = pick(g_req);

    // Vector of a group
    function automatic logic [15:0] gvec(input logic [2:0] g);
        unique case (g)
            3'h0:    gvec = `VPIU_VEC_G2;
            3'h1:    gvec = `VPIU_VEC_G3;
            3'h2:    gvec = `VPIU_VEC_G4;
            3'h3:    gvec = `VPIU_VEC_G5;
            default: gvec = `VPIU_VEC_G6;
        endcase
    endfunction

    // Clear a lone unmasked flag only; shared both-unmasked flags stay
    wire [1:0] pair = elig[2*grp +: 2];
    wire [1:0] pm   = mask[2*grp +: 2];
    wire [1:0] lone = (pm == 2'b00) ? 2'b00 : pair;
    wire [10:0] grp_clr = 11'(lone) << (2*grp);

    // Skip test decode; index 10 reads the NMI pin, never its flag
    wire        t_is_flag = (i_test_sel < 5'd10);
    wire        t_is_pin  = (i_test_sel == 5'd10);
    wire        t_is_tf   = (i_test_sel > 5'd10) && (i_test_sel < 5'd18);
    wire [4:0]  t_tf_idx  = i_test_sel - 5'd11;
    wire [10:0] t_clr = (i_test_req && t_is_flag) ?
                        (11'h001 << i_test_sel[3:0]) : 11'h000;
    wire [6:0]  tf_clr = (i_test_req && t_is_tf) ?
                        (7'h01 << t_tf_idx[2:0]) : 7'h00;

    // ****************************************************************
    // Request and test flags; set wins over clear
    // ****************************************************************
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            flags  <= 11'h000;
            tflags <= 7'h00;
        end else begin
            flags  <= (flags & ~(ack_clr | t_clr)) | set_ev;
            tflags <= (tflags & ~tf_clr) | tset;
        end
    end

    // Acknowledge clear mask chosen at start
    always_comb begin
        ack_clr = 11'h000;
        if (start && nmi_take) begin
            ack_clr[`VPIU_SRC_NMI] = 1'b1;
        end else if (start && msk_take) begin
            ack_clr = grp_clr;
        end
    end

    // ****************************************************************
    // Pin history
    // ****************************************************************
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            nmi_q <= 1'b1;
            ci_q  <= 1'b0;
            to_q  <= 1'b0;
            an_q  <= 4'h0;
        end else begin
            nmi_q <= i_nmi_pin_n;
            ci_q  <= i_counter_input_pin;
            to_q  <= i_timer_output;
            an_q  <= i_analog_pin;
        end
    end

    // ****************************************************************
    // Mask register
    // ****************************************************************
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            mask <= `VPIU_MASK_RST;
        end else if (i_hw_stop) begin
            mask <= `VPIU_MASK_RST;
        end else if (i_mask_sel < 4'(`VPIU_NUM_MSK)) begin
            // Bit 7 is converter mask: high half bit zero
            if (i_mask_set) mask[i_mask_sel] <= 1'b1;
            else if (i_mask_clr) mask[i_mask_sel] <= 1'b0;
        end
    end

    // ****************************************************************
    // Global enable
    // ****************************************************************
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            global_enable_ff <= 1'b0;
        end else if (start && (nmi_take || msk_take)) begin
            global_enable_ff <= 1'b0;
        end else if (i_enable_irq_instr) begin
            global_enable_ff <= 1'b1;
        end else if (i_disable_irq_instr) begin
            global_enable_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // Acknowledge sequencer
    // ****************************************************************
    wire step_done = (cyc == 4'h3);   // Four cycles per step
    always_comb begin
        next_state = state;
        unique case (state)
            vpiu_pkg::VPIU_IDLE: if (start) next_state = vpiu_pkg::VPIU_PSW;
            vpiu_pkg::VPIU_PSW:  if (step_done) next_state = vpiu_pkg::VPIU_PCH;
            vpiu_pkg::VPIU_PCH:  if (step_done) next_state = vpiu_pkg::VPIU_PCL;
            vpiu_pkg::VPIU_PCL:  if (step_done) next_state = vpiu_pkg::VPIU_VEC;
            vpiu_pkg::VPIU_VEC:  if (step_done) next_state = vpiu_pkg::VPIU_IDLE;
            default:             next_state = vpiu_pkg::VPIU_IDLE;
        endcase
    end

    // Latch context and vector at start
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state    <= vpiu_pkg::VPIU_IDLE;
            cyc      <= 4'h0;
            kind     <= vpiu_pkg::VPIU_K_NMI;
            vec_hold <= 16'h0000;
            pc_hold  <= 16'h0000;
            psw_hold <= 8'h00;
        end else begin
            state <= next_state;
            cyc   <= (state == vpiu_pkg::VPIU_IDLE || step_done) ?
                     4'h0 : cyc + 4'h1;
            if (start) begin
                pc_hold  <= i_pc;
                psw_hold <= i_status_word;
                if (nmi_take) begin
                    kind     <= vpiu_pkg::VPIU_K_NMI;
                    vec_hold <= `VPIU_VEC_NMI;
                end else if (msk_take) begin
                    kind     <= vpiu_pkg::VPIU_K_MSK;
                    vec_hold <= gvec(grp);
                end else begin
                    kind     <= vpiu_pkg::VPIU_K_TRAP;
                    vec_hold <= `VPIU_VEC_TRAP;
                    // Trap runs even after a skip; skip stacked set
                    psw_hold[`VPIU_SKIP_BIT] <= i_status_word[`VPIU_SKIP_BIT]
                                                | i_skip_pending;
                end
            end
        end
    end

    // ****************************************************************
    // Outputs to the core
    // ****************************************************************
    wire first = (cyc == 4'h0);
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_push_valid   <= 1'b0;
            o_push_data    <= 8'h00;
            o_vector_valid <= 1'b0;
            o_vector       <= 16'h0000;
            o_test_result  <= 1'b0;
        end else begin
            o_push_valid   <= first && (state == vpiu_pkg::VPIU_PSW ||
                              state == vpiu_pkg::VPIU_PCH ||
                              state == vpiu_pkg::VPIU_PCL);
            o_push_data    <= (state == vpiu_pkg::VPIU_PSW) ? psw_hold :
                              (state == vpiu_pkg::VPIU_PCH) ?
                              pc_hold[15:8] : pc_hold[7:0];
            o_vector_valid <= (state == vpiu_pkg::VPIU_VEC) && step_done;
            o_vector       <= vec_hold;
            if (i_test_req) begin
                o_test_result <= t_is_flag ? flags[i_test_sel[3:0]] :
                                 t_is_pin  ? i_nmi_pin_n :
                                 t_is_tf   ? tflags[t_tf_idx[2:0]] : 1'b0;
            end
        end
    end

    assign o_busy             = (state != vpiu_pkg::VPIU_IDLE) || start;
    assign o_global_enable_ff = global_enable_ff;
    assign o_mask             = mask;
    assign o_flags            = flags;
endmodule

// >>> vpiu_core_asserts.sv
// Port checker of the vectored priority interrupt unit
`timescale 1ns/1ps
`include "vpiu_cfg.svh"
module vpiu_core_asserts (
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    input wire logic        i_enable_irq_instr,
    input wire logic        i_disable_irq_instr,
    input wire logic        i_hw_stop,
    input wire logic        i_mask_set,
    input wire logic        i_mask_clr,
    input wire logic [3:0]  i_mask_sel,
    input wire logic        i_test_req,
    input wire logic [4:0]  i_test_sel,
    input wire logic        o_busy,
    input wire logic        o_push_valid,
    input wire logic        o_vector_valid,
    input wire logic        o_test_result,
    input wire logic        o_global_enable_ff,
    input wire logic [9:0]  o_mask,
    input wire logic [10:0] o_flags
);
    logic exp_bit; // Flag value seen by the last test request
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // Capture the tested flag at the request edge
    always_ff @(posedge i_clk_sys) exp_bit <= o_flags[i_test_sel[3:0]];
    // Three context pushes four cycles apart
    sequence s_stack;
        ##2 o_push_valid ##4 o_push_valid ##4 o_push_valid;
    endsequence
    property p_walk;
        $rose(o_busy) |-> s_stack ##7 o_vector_valid;
    endproperty
    a_walk: assert property (p_walk) else $error("bad push order");
    property p_stall;
        $rose(o_busy) |-> o_busy [*8];
    endproperty
    a_stall: assert property (p_stall) else $error("busy dropped");
    property p_rst_state;
        $fell(i_rst) |-> o_mask == `VPIU_MASK_RST && o_flags == 11'h000
            && !o_global_enable_ff;
    endproperty
    a_rst_state: assert property (p_rst_state) else $error("reset state");
    property p_stop;
        i_hw_stop |=> o_mask == `VPIU_MASK_RST;
    endproperty
    a_stop: assert property (p_stop) else $error("stop mask");
    property p_mset;
        i_mask_set && i_mask_sel < 4'ha |=> o_mask[$past(i_mask_sel)];
    endproperty
    a_mset: assert property (p_mset) else $error("mask set");
    property p_mclr;
        i_mask_clr && !i_mask_set && !i_hw_stop && i_mask_sel < 4'ha
            |=> !o_mask[$past(i_mask_sel)];
    endproperty
    a_mclr: assert property (p_mclr) else $error("mask clear");
    property p_ei;
        i_enable_irq_instr && !i_disable_irq_instr && !o_busy
            |=> o_global_enable_ff;
    endproperty
    a_ei: assert property (p_ei) else $error("enable");
    property p_di;
        i_disable_irq_instr && !i_enable_irq_instr |=> !o_global_enable_ff;
    endproperty
    a_di: assert property (p_di) else $error("disable");
    property p_nmi;
        $rose(o_busy) && o_flags[10] |=> !o_global_enable_ff && !o_flags[10];
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi entry");
    property p_test;
        i_test_req && i_test_sel < 5'h0a |=> o_test_result == exp_bit;
    endproperty
    a_test: assert property (p_test) else $error("test result");
endmodule
bind vpiu_core vpiu_core_asserts u_asserts (.i_clk_sys, .i_rst,
    .i_enable_irq_instr, .i_disable_irq_instr, .i_hw_stop, .i_mask_set,
    .i_mask_clr, .i_mask_sel, .i_test_req, .i_test_sel, .o_busy,
    .o_push_valid, .o_vector_valid, .o_test_result, .o_global_enable_ff,
    .o_mask, .o_flags);

// >>> vpiu_cpu_model.sv
// Core model: instruction boundaries and stack capture
`timescale 1ns/1ps
module vpiu_cpu_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_busy,
    input  wire logic        i_push_valid,
    input  wire logic [7:0]  i_push_data,
    input  wire logic        i_vector_valid,
    input  wire logic [15:0] i_vector,
    output logic             o_instr_end
);
    logic [7:0]  stk [0:2];   // Last stacked context
    logic [1:0]  np  = 2'h0;  // Push position
    logic [1:0]  cnt = 2'h0;  // Instruction length count
    logic [15:0] vec = 16'h0; // Last vector loaded
    int          nv  = 0;     // Vectors loaded
    initial o_instr_end = 1'h0;
    // Boundary every fourth cycle, none while fetch is stalled
    always @(negedge i_clk_sys) begin
        cnt <= cnt + 2'h1;
        o_instr_end <= (cnt == 2'h0) && !i_busy;
    end
    // Stack writes in arrival order, then vector load
    always @(posedge i_clk_sys) begin
        if (i_push_valid) begin
            stk[np] <= i_push_data;
            np <= (np == 2'h2) ? 2'h0 : np + 2'h1;
        end
        if (i_vector_valid) begin
            vec <= i_vector;
            nv <= nv + 1;
        end
    end
endmodule

// >>> tb_top.sv
// Self-checking bench of the vectored priority interrupt unit
`timescale 1ns/1ps
`include "vpiu_cfg.svh"
module tb_top;
    logic i_clk_sys = 1'h0, i_rst = 1'h1, i_nmi_pin_n = 1'h1, i_instr_end;
    logic i_timer_a_match_irq = 1'h0, i_timer_b_match_irq = 1'h0;
    logic i_ext_rising_pin = 1'h0, i_ext_falling_pin = 1'h1;
    logic i_event_cmp_a_irq = 1'h0, i_event_cmp_b_irq = 1'h0;
    logic i_counter_input_pin = 1'h1, i_timer_output = 1'h0;
    logic i_converter_done_irq = 1'h0, i_rx_full_irq = 1'h0;
    logic i_tx_empty_irq = 1'h0, i_counter_overflow_test = 1'h0;
    logic i_serial_error_test = 1'h0, i_supply_rise_test = 1'h0;
    logic i_enable_irq_instr = 1'h0, i_disable_irq_instr = 1'h0;
    logic i_software_trap_instr = 1'h0, i_skip_pending = 1'h0;
    logic i_hw_stop = 1'h0, i_mask_set = 1'h0, i_mask_clr = 1'h0;
    logic i_test_req = 1'h0, o_busy, o_push_valid, o_vector_valid;
    logic o_test_result, o_global_enable_ff;
    logic [3:0]  i_analog_pin = 4'hf, i_mask_sel = 4'h0;
    logic [4:0]  i_test_sel = 5'h00;
    logic [7:0]  i_status_word = 8'h12, o_push_data;
    logic [15:0] i_pc = 16'ha5c3, o_vector;
    logic [9:0]  o_mask;
    logic [10:0] o_flags;
    int          bad_count = 0, n_checks = 0;
    vpiu_core DUT (.i_clk_sys, .i_rst, .i_nmi_pin_n, .i_timer_a_match_irq,
        .i_timer_b_match_irq, .i_ext_rising_pin, .i_ext_falling_pin,
        .i_event_cmp_a_irq, .i_event_cmp_b_irq, .i_counter_input_pin,
        .i_timer_output, .i_converter_done_irq, .i_rx_full_irq,
        .i_tx_empty_irq, .i_counter_overflow_test, .i_serial_error_test,
        .i_supply_rise_test, .i_analog_pin, .i_instr_end,
        .i_enable_irq_instr, .i_disable_irq_instr, .i_software_trap_instr,
        .i_skip_pending, .i_hw_stop, .i_mask_set, .i_mask_clr, .i_mask_sel,
        .i_test_req, .i_test_sel, .i_status_word, .i_pc, .o_busy,
        .o_push_valid, .o_push_data, .o_vector_valid, .o_vector,
        .o_test_result, .o_global_enable_ff, .o_mask, .o_flags);
    vpiu_cpu_model CPU (.i_clk_sys, .i_busy(o_busy), .i_push_data(o_push_data),
        .i_push_valid(o_push_valid), .i_vector_valid(o_vector_valid),
        .i_vector(o_vector), .o_instr_end(i_instr_end));
    // Clock, 4 ns period
    initial forever #2 i_clk_sys = ~i_clk_sys;
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    task automatic ei();
        i_enable_irq_instr = 1'h1;
        tick(1);
        i_enable_irq_instr = 1'h0;
    endtask
    task automatic mclr(logic [3:0] s);
        {i_mask_clr, i_mask_sel} = {1'h1, s};
        tick(1);
        i_mask_clr = 1'h0;
        tick(1);
    endtask
    task automatic t_test(logic [4:0] s, logic e);
        {i_test_req, i_test_sel} = {1'h1, s};
        tick(1);
        i_test_req = 1'h0;
        tick(1);
        chk("test_result", {15'h0, e}, {15'h0, o_test_result});
    endtask
    task automatic wait_vec(logic [15:0] v);
        int n0;
        n0 = CPU.nv;
        for (int k = 0; k < 40 && CPU.nv == n0; k++) tick(1);
        chk("vector", v, CPU.vec);
    endtask
    task automatic ctx(logic [7:0] status_word);
        chk("stack", {status_word, i_pc[15:8]}, {CPU.stk[0], CPU.stk[1]});
        chk("pc_low", {8'h0, i_pc[7:0]}, {8'h0, CPU.stk[2]});
    endtask
    // Nonmaskable entry clears enable and its flag
    task automatic t_nmi();
        ei();
        i_nmi_pin_n = 1'h0;
        wait_vec(`VPIU_VEC_NMI);
        i_nmi_pin_n = 1'h1;
        ctx(i_status_word);
        chk("nmi", 16'h0, {14'h0, o_global_enable_ff, o_flags[10]});
    endtask
    // Test flags read once set, then clear
    task automatic t_flags();
        {i_counter_overflow_test, i_serial_error_test} = 2'h3;
        {i_supply_rise_test, i_analog_pin} = 5'h10;
        tick(1);
        {i_counter_overflow_test, i_serial_error_test} = 2'h0;
        i_supply_rise_test = 1'h0;
        tick(1);
        t_test(5'h0a, 1'h1);
        for (int s = 22; s < 36; s++) t_test(5'(s >> 1), !s[0]);
    endtask
    // All ten sources pending, serviced group by group
    task automatic t_groups();
        for (int b = 0; b < 10; b++) mclr(4'(b));
        {i_timer_a_match_irq, i_timer_b_match_irq} = 2'h3;
        {i_event_cmp_a_irq, i_event_cmp_b_irq, i_converter_done_irq} = 3'h7;
        {i_rx_full_irq, i_tx_empty_irq, i_ext_rising_pin} = 3'h7;
        {i_ext_falling_pin, i_counter_input_pin} = 2'h0;
        tick(1);
        {i_timer_a_match_irq, i_timer_b_match_irq} = 2'h0;
        {i_event_cmp_a_irq, i_event_cmp_b_irq, i_converter_done_irq} = 3'h0;
        {i_rx_full_irq, i_tx_empty_irq} = 2'h0;
        tick(5);
        chk("ext_early", 16'h0, {14'h0, o_flags[3:2]});
        tick(8);
        {i_ext_rising_pin, i_ext_falling_pin} = 2'h1;
        chk("flags", 16'h03ff, {5'h0, o_flags});
        for (int g = 0; g < 5; g++) begin
            ei();
            wait_vec(16'(8 * g + 8));
            chk("pair", 16'h3, {14'h0, o_flags[2 * g +: 2]});
            chk("enable", 16'h0, {15'h0, o_global_enable_ff});
            for (int h = 0; h < 2; h++) t_test(5'(2 * g + h), 1'h1);
        end
        chk("flags", 16'h0, {5'h0, o_flags});
    endtask
    // One source of a pair unmasked, then both
    task automatic t_single();
        i_mask_set = 1'h1;
        tick(1);
        chk("mask_set", 16'h0200, {6'h0, o_mask});
        {i_mask_set, i_hw_stop} = 2'h1;
        tick(1);
        i_hw_stop = 1'h0;
        chk("mask", 16'h03ff, {6'h0, o_mask});
        mclr(4'h0);
        {i_timer_a_match_irq, i_timer_b_match_irq} = 2'h3;
        tick(1);
        {i_timer_a_match_irq, i_timer_b_match_irq} = 2'h0;
        tick(8);
        chk("held", 16'h3, {14'h0, o_flags[1:0]});
        ei();
        wait_vec(`VPIU_VEC_G2);
        chk("pair", 16'h2, {14'h0, o_flags[1:0]});
        mclr(4'h1);
        ei();
        wait_vec(`VPIU_VEC_G2);
        chk("pair", 16'h2, {14'h0, o_flags[1:0]});
        t_test(5'h01, 1'h1);
    endtask
    // Trap after a met skip, enable left set
    task automatic t_trap();
        ei();
        {i_skip_pending, i_software_trap_instr} = 2'h3;
        for (int k = 0; k < 20 && CPU.np == 2'h0; k++) tick(1);
        {i_skip_pending, i_software_trap_instr} = 2'h0;
        wait_vec(`VPIU_VEC_TRAP);
        ctx(i_status_word | 8'h20);
        chk("enable", 16'h1, {15'h0, o_global_enable_ff});
        i_disable_irq_instr = 1'h1;
        tick(1);
        chk("disable", 16'h0, {15'h0, o_global_enable_ff});
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #40000;
        bad_count++;
        summarize();
    end
    initial begin
        tick(8);
        i_rst = 1'h0;
        tick(1);
        chk("reset", 16'h03ff, {6'h0, o_mask});
        chk("reset", 16'h0, {4'h0, o_global_enable_ff, o_flags});
        t_nmi();
        t_flags();
        t_groups();
        t_single();
        t_trap();
        summarize();
    end
endmodule
